// ===== design/jsrb_register_bank.sv
`timescale 1ns/100ps

module jsrb_register_bank #(
    parameter int         RAW_WIDTH   = jsrb_pkg::RAW_WIDTH_DEFAULT,
    parameter int         SCALE_SHIFT = jsrb_pkg::SCALE_SHIFT_DEFAULT,
    parameter logic [7:0] ID_MAKER    = jsrb_pkg::ID_MAKER_DEFAULT,   // Arbitrary value
    parameter logic [7:0] COMPONENT_VERSION  = jsrb_pkg::COMPONENT_VERSION_DEFAULT, // Arbitrary value
    parameter logic [7:0] ID_REVISION = jsrb_pkg::ID_REVISION_DEFAULT // Arbitrary value
) (
    input  wire logic                   sys_clk,      // System clock, 20 MHz
    input  wire logic                   rst_n,        // Async reset, active low
    input  wire jsrb_pkg::jsrb_req_t    regReq,       // Register access from bus front end
    input  wire logic                   regRdAck,     // Ack bit of a read byte completed
    output logic [7:0]                  regRdata,     // Read data, valid after rd
    input  wire logic                   calcStart,    // Coordinate calculation begins
    input  wire logic                   calcDone,     // Coordinate calculation ends
    input  wire logic [RAW_WIDTH-1:0]   rawX,         // Signed raw X, valid with calcDone
    input  wire logic [RAW_WIDTH-1:0]   rawY,         // Signed raw Y, valid with calcDone
    output jsrb_pkg::jsrb_cfg_t         measCfg,      // Mode, time base, test/polarity
    output logic                        irqOutLowOut, // Interrupt pin level when driven
    output logic                        irqOutLowOe   // Interrupt pin drive enable
);
    import jsrb_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic       idleMode;
    logic [2:0] lowPowerTimebase;
    logic       intDisable;
    logic       intFunction;
    logic       dataValid;
    logic [7:0] xResult;
    logic [7:0] yResult;
    logic [7:0] scalingControl;
    logic [7:0] testPolarityControl;
    logic [7:0] limitReg [NUM_LIMITS];
    logic       irqPending;
    logic [7:0] lastReadAddr;

    logic       softReset;
    logic       wrCtl;
    logic       wrScaling;
    logic       wrTestPol;
    logic       wrLimit [NUM_LIMITS];
    logic [7:0] scaledX;
    logic [7:0] scaledY;
    logic       outside;
    logic       irqEvent;
    logic       yReadAcked;
    logic       next_irqPending;
    logic [7:0] next_regRdata;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // Soft reset takes effect on the write itself, so the bit never reads back one
    assign wrCtl     = regReq.wr && (regReq.addr == ADDR_MAIN_CONTROL);
    assign softReset = wrCtl && regReq.wdata[CTL_SOFT_RST];
    // Identification and result addresses decode to nothing, so writes there fall away
    assign wrScaling = regReq.wr && (regReq.addr == ADDR_SCALING);
    assign wrTestPol = regReq.wr && (regReq.addr == ADDR_TEST_POL);

    // ------------------------------------------------------------
    // Scaling
    // ------------------------------------------------------------
    // Saturate so that an oversized factor clips instead of wrapping sign
    function automatic logic [7:0] scaleSat(input logic [RAW_WIDTH-1:0] raw,
                                            input logic [7:0]           factor);
        logic signed [RAW_WIDTH+9:0] prod;
        logic signed [RAW_WIDTH+9:0] shifted;
        prod    = $signed({{10{raw[RAW_WIDTH-1]}}, raw}) *
                  $signed({{(RAW_WIDTH+2){1'b0}}, factor});
        shifted = prod >>> SCALE_SHIFT;
        if (shifted > $signed((RAW_WIDTH+10)'(127))) begin
            scaleSat = 8'h7f;
        end else if (shifted < -$signed((RAW_WIDTH+10)'(128))) begin
            scaleSat = 8'h80;
        end else begin
            scaleSat = shifted[7:0];
        end
    endfunction

    assign scaledX = scaleSat(rawX, scalingControl);
    assign scaledY = scaleSat(rawY, scalingControl);

    // ------------------------------------------------------------
    // Scaling and test/polarity registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scalingControl <= RST_SCALING;
        end else if (softReset) begin
            scalingControl <= RST_SCALING;
        end else if (wrScaling) begin
            scalingControl <= regReq.wdata;
        end
    end

    // Stored as written; the test bits are the host's to keep legal
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            testPolarityControl <= RST_TEST_POL;
        end else if (softReset) begin
            testPolarityControl <= RST_TEST_POL;
        end else if (wrTestPol) begin
            testPolarityControl <= regReq.wdata;
        end
    end

    // ------------------------------------------------------------
    // Main control
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idleMode         <= RST_IDLE;
            lowPowerTimebase <= RST_TIMEBASE;
        end else if (softReset) begin
            idleMode         <= RST_IDLE;
            lowPowerTimebase <= RST_TIMEBASE;
        end else if (wrCtl) begin
            idleMode         <= regReq.wdata[CTL_IDLE_BIT];
            lowPowerTimebase <= regReq.wdata[CTL_TB_HI:CTL_TB_LO];
        end
    end

    // Interrupt set-up shares the byte but is a concern of its own
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            intDisable  <= RST_INT_DIS;
            intFunction <= RST_INT_FUNC;
        end else if (softReset) begin
            intDisable  <= RST_INT_DIS;
            intFunction <= RST_INT_FUNC;
        end else if (wrCtl) begin
            intDisable  <= regReq.wdata[CTL_INT_DIS];
            intFunction <= regReq.wdata[CTL_INT_FUNC];
        end
    end

    // Done wins if start and done coincide
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataValid <= RST_VALID;
        end else if (softReset) begin
            dataValid <= RST_VALID;
        end else if (calcDone) begin
            dataValid <= 1'b1;
        end else if (calcStart) begin
            dataValid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xResult <= RST_RESULT;
            yResult <= RST_RESULT;
        end else if (softReset) begin
            xResult <= RST_RESULT;
            yResult <= RST_RESULT;
        end else if (calcDone) begin
            // One edge loads both, so X and Y never come from different passes
            xResult <= scaledX;
            yResult <= scaledY;
        end
    end

    // ------------------------------------------------------------
    // Threshold registers
    // ------------------------------------------------------------
    localparam logic [7:0] LIMIT_RST [NUM_LIMITS] = '{RST_LEFT, RST_RIGHT, RST_TOP, RST_BOTTOM};

    for (genvar i = 0; i < NUM_LIMITS; i++) begin : g_limit
        assign wrLimit[i] = regReq.wr && (regReq.addr == ADDR_LIMIT_BASE + 8'(i));
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                limitReg[i] <= LIMIT_RST[i];
            end else if (softReset) begin
                limitReg[i] <= LIMIT_RST[i];
            end else if (wrLimit[i]) begin
                limitReg[i] <= regReq.wdata;
            end
        end
    end

    // Compared against the freshly scaled pair, the one about to be stored
    assign outside = ($signed(scaledX) > $signed(limitReg[LIM_LEFT]))  ||
                     ($signed(scaledX) < $signed(limitReg[LIM_RIGHT])) ||
                     ($signed(scaledY) > $signed(limitReg[LIM_TOP]))   ||
                     ($signed(scaledY) < $signed(limitReg[LIM_BOTTOM]));

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    // Clear waits for the ack bit of the Y byte, not its read strobe
    assign yReadAcked = regRdAck && (lastReadAddr == ADDR_Y_RESULT);
    // Disabled events are dropped, not held back for a later enable
    assign irqEvent   = calcDone && !intDisable && (!intFunction || outside);

    // A new event in the clearing cycle keeps the flag set
    always_comb begin
        next_irqPending = irqPending;
        if (yReadAcked) begin
            next_irqPending = 1'b0;
        end
        if (irqEvent) begin
            next_irqPending = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqPending <= 1'b0;
        end else if (softReset) begin
            irqPending <= 1'b0;
        end else begin
            irqPending <= next_irqPending;
        end
    end

    // Open drain: only ever pulls low
    assign irqOutLowOut = 1'b0;
    assign irqOutLowOe  = irqPending && !intDisable;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lastReadAddr <= 8'h00;
        end else if (softReset) begin
            lastReadAddr <= 8'h00;
        end else if (regReq.rd) begin
            lastReadAddr <= regReq.addr;
        end
    end

    // Mux is combinational; the data output is a flop held until the next read
    always_comb begin
        next_regRdata = RST_RDATA;
        unique case (regReq.addr)
            ADDR_MAKER_CODE:   next_regRdata = ID_MAKER;
            ADDR_COMP_VERSION: next_regRdata = COMPONENT_VERSION;
            ADDR_SI_REVISION:  next_regRdata = ID_REVISION;
            ADDR_MAIN_CONTROL: next_regRdata = {idleMode, lowPowerTimebase, intDisable,
                                                intFunction, 1'b0, dataValid};
            ADDR_X_RESULT:     next_regRdata = xResult;
            ADDR_Y_RESULT:     next_regRdata = yResult;
            ADDR_LIMIT_BASE:   next_regRdata = limitReg[LIM_LEFT];
            ADDR_LIMIT_BASE + 8'h01: next_regRdata = limitReg[LIM_RIGHT];
            ADDR_LIMIT_BASE + 8'h02: next_regRdata = limitReg[LIM_TOP];
            ADDR_LIMIT_BASE + 8'h03: next_regRdata = limitReg[LIM_BOTTOM];
            ADDR_SCALING:      next_regRdata = scalingControl;
            ADDR_TEST_POL:     next_regRdata = testPolarityControl;
            // Unmapped addresses read as zero
            default:           next_regRdata = RST_RDATA;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= RST_RDATA;
        end else if (regReq.rd) begin
            regRdata <= next_regRdata;
        end
    end

    // ------------------------------------------------------------
    // Configuration out to the measurement side
    // ------------------------------------------------------------
    assign measCfg = '{idle:     idleMode,
                       timebase: lowPowerTimebase,
                       testPol:  testPolarityControl};

endmodule

// ===== design/jsrb_pkg.sv
package jsrb_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MAKER_CODE   = 8'h0c;
    localparam logic [7:0] ADDR_COMP_VERSION = 8'h0d;
    localparam logic [7:0] ADDR_SI_REVISION  = 8'h0e;
    localparam logic [7:0] ADDR_MAIN_CONTROL = 8'h0f;
    localparam logic [7:0] ADDR_X_RESULT     = 8'h10;
    localparam logic [7:0] ADDR_Y_RESULT     = 8'h11;
    localparam logic [7:0] ADDR_LIMIT_BASE   = 8'h12;
    localparam logic [7:0] ADDR_SCALING      = 8'h2d;
    localparam logic [7:0] ADDR_TEST_POL     = 8'h2e;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SCALING  = 8'h09;
    localparam logic [7:0] RST_TEST_POL = 8'h84;
    localparam logic [7:0] RST_RESULT   = 8'h00;
    localparam logic [7:0] RST_LEFT     = 8'h05;
    localparam logic [7:0] RST_RIGHT    = 8'hfb;
    localparam logic [7:0] RST_TOP      = 8'h05;
    localparam logic [7:0] RST_BOTTOM   = 8'hfb;
    localparam logic       RST_IDLE     = 1'b1;
    localparam logic [2:0] RST_TIMEBASE = 3'h7;
    localparam logic       RST_INT_DIS  = 1'b0;
    localparam logic       RST_INT_FUNC = 1'b0;
    localparam logic       RST_VALID    = 1'b0;
    localparam logic [7:0] RST_RDATA    = 8'h00;

    // Arbitrary identification values
    localparam logic [7:0] ID_MAKER_DEFAULT   = 8'ha5;
    localparam logic [7:0] COMPONENT_VERSION_DEFAULT = 8'h31;
    localparam logic [7:0] ID_REVISION_DEFAULT = 8'h02;

    // ------------------------------------------------------------
    // Main control field positions
    // ------------------------------------------------------------
    localparam int CTL_IDLE_BIT  = 7;
    localparam int CTL_TB_HI     = 6;
    localparam int CTL_TB_LO     = 4;
    localparam int CTL_INT_DIS   = 3;
    localparam int CTL_INT_FUNC  = 2;
    localparam int CTL_SOFT_RST  = 1;
    localparam int CTL_VALID_BIT = 0;

    localparam int NUM_LIMITS   = 4;
    localparam int LIM_LEFT     = 0;
    localparam int LIM_RIGHT    = 1;
    localparam int LIM_TOP      = 2;
    localparam int LIM_BOTTOM   = 3;

    localparam int RAW_WIDTH_DEFAULT   = 12;
    localparam int SCALE_SHIFT_DEFAULT = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } jsrb_req_t;

    typedef struct packed {
        logic       idle;
        logic [2:0] timebase;
        logic [7:0] testPol;
    } jsrb_cfg_t;

endpackage

// ===== dv/jsrb_properties.sv
`timescale 1ns/100ps
module jsrb_properties #(
    parameter logic [7:0] ID_MAKER = jsrb_pkg::ID_MAKER_DEFAULT // Arbitrary value
) (
    input wire logic                sys_clk,     // Clock
    input wire logic                rst_n,       // Async reset
    input wire jsrb_pkg::jsrb_req_t regReq,      // Register access
    input wire logic                regRdAck,    // Read byte acked
    input wire logic [7:0]          regRdata,    // Read data
    input wire logic                calcDone,    // Calculation end
    input wire jsrb_pkg::jsrb_cfg_t measCfg,     // Config out
    input wire logic                irqOutLowOe  // Pin enable
);
    import jsrb_pkg::*;
    logic ctlWr;
    assign ctlWr = regReq.wr && (regReq.addr == ADDR_MAIN_CONTROL);
    logic irqEnWr;
    assign irqEnWr = ctlWr && !regReq.wdata[CTL_INT_DIS];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------
    irq_set_a: assert property ($rose(irqOutLowOe) |->
        $past(calcDone) || $past(calcDone, 2) || $past(irqEnWr))
        else $error("irq rose with no new result");
    irq_release_a: assert property ($fell(irqOutLowOe) |->
        $past(regRdAck) || $past(ctlWr)) else $error("irq released with no ack");
    irq_hold_a: assert property (irqOutLowOe && !regRdAck && !ctlWr |=>
        irqOutLowOe) else $error("irq dropped on its own");
    irq_disable_a: assert property (ctlWr && regReq.wdata[3] |=>
        !irqOutLowOe) else $error("irq driven while disabled");
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    id_read_a: assert property (regReq.rd && regReq.addr == ADDR_MAKER_CODE |=>
        regRdata == ID_MAKER) else $error("maker code read wrong");
    unmapped_read_a: assert property (regReq.rd && regReq.addr > ADDR_TEST_POL |=>
        regRdata == 8'h00) else $error("unmapped read not zero");
    mode_write_a: assert property (ctlWr && !regReq.wdata[1] |=>
        measCfg.idle == $past(regReq.wdata[7]) && measCfg.timebase == $past(regReq.wdata[6:4]))
        else $error("mode fields not taken");
    testpol_write_a: assert property (regReq.wr && regReq.addr == ADDR_TEST_POL |=>
        measCfg.testPol == $past(regReq.wdata)) else $error("test register not taken");
    soft_reset_a: assert property (ctlWr && regReq.wdata[1] |=>
        measCfg == {1'b1, 3'h7, 8'h84} && !irqOutLowOe) else $error("soft reset incomplete");
    reset_values_a: assert property ($rose(rst_n) |->
        measCfg == {1'b1, 3'h7, 8'h84} && !irqOutLowOe) else $error("reset values wrong");
endmodule

// ===== dv/jsrb_host_model.sv
`timescale 1ns/100ps
module jsrb_host_model (
    input  wire logic           sys_clk,  // Bus clock
    input  wire logic [7:0]     regRdata, // Read data
    output jsrb_pkg::jsrb_req_t regReq,   // Access strobes
    output logic                regRdAck  // Read byte acked
);
    import jsrb_pkg::*;
    initial begin
        regReq = '{addr: 8'hff, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        regRdAck = 1'b0;
    end
    // Released fields show the inverse so stale values cannot pass
    task automatic writeReg(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        regReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(negedge sys_clk);
        regReq <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
    endtask
    task automatic readReg(input logic [7:0] a, output logic [7:0] v);
        @(negedge sys_clk);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge sys_clk);
        regReq <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        v = regRdata;
    endtask
    task automatic ackByte();
        @(negedge sys_clk);
        regRdAck <= 1'b1;
        @(negedge sys_clk);
        regRdAck <= 1'b0;
    endtask
endmodule

// ===== dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    import jsrb_pkg::*;
    logic       sys_clk;
    logic       rst_n;
    jsrb_req_t  regReq;
    logic       regRdAck;
    logic [7:0] regRdata;
    logic       calcStart;
    logic       calcDone;
    logic [11:0] rawX;
    logic [11:0] rawY;
    jsrb_cfg_t  measCfg;
    logic       irqOutLowOe;
    logic       irqOutLowOut;
    logic [7:0] d;
    int         mismatches;
    int         check_count;
    logic [7:0] mapAddr [12] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11,
                                 8'h12, 8'h13, 8'h14, 8'h15, 8'h2d, 8'h2e};
    logic [7:0] mapExp [12] = '{ID_MAKER_DEFAULT, COMPONENT_VERSION_DEFAULT, ID_REVISION_DEFAULT,
                                8'hf0, 8'h00, 8'h00, 8'h05, 8'hfb, 8'h05, 8'hfb, 8'h09, 8'h84};
    jsrb_register_bank u_jsrb_register_bank (.sys_clk(sys_clk), .rst_n(rst_n),
        .regReq(regReq), .regRdAck(regRdAck), .regRdata(regRdata), .calcStart(calcStart),
        .calcDone(calcDone), .rawX(rawX), .rawY(rawY), .measCfg(measCfg),
        .irqOutLowOut(irqOutLowOut), .irqOutLowOe(irqOutLowOe));
    jsrb_host_model u_jsrb_host_model (.sys_clk(sys_clk), .regRdata(regRdata),
        .regReq(regReq), .regRdAck(regRdAck));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    function automatic logic [7:0] scaled(input int raw, input int sc);
        int p;
        p = (raw * sc) >>> 4;
        if (p > 127) p = 127;
        if (p < -128) p = -128;
        return p[7:0];
    endfunction
    task automatic close_out();
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        u_jsrb_host_model.readReg(a, d);
        u_jsrb_host_model.ackByte();
        check(d, e);
    endtask
    // Pin must hold until the ack of the Y byte, not the read strobe
    task automatic yRead(input logic [7:0] e, input logic oe);
        u_jsrb_host_model.readReg(ADDR_Y_RESULT, d);
        check(d, e);
        check({7'h00, irqOutLowOe}, {7'h00, oe});
        u_jsrb_host_model.ackByte();
        check({7'h00, irqOutLowOe}, 8'h00);
    endtask
    task automatic meas(input int x, input int y, input int sc, input logic oe);
        @(negedge sys_clk);
        calcStart = 1'b1;
        @(negedge sys_clk);
        calcStart = 1'b0;
        u_jsrb_host_model.readReg(ADDR_MAIN_CONTROL, d);
        check(d & 8'h01, 8'h00);
        rawX = x[11:0];
        rawY = y[11:0];
        calcDone = 1'b1;
        @(negedge sys_clk);
        calcDone = 1'b0;
        rawX = ~rawX;
        rawY = ~rawY;
        @(negedge sys_clk);
        check({6'h00, irqOutLowOe, irqOutLowOut}, {6'h00, oe, 1'b0});
        u_jsrb_host_model.readReg(ADDR_MAIN_CONTROL, d);
        check(d & 8'h01, 8'h01);
        rdChk(ADDR_X_RESULT, scaled(x, sc));
    endtask
    task automatic mapCheck();
        for (int i = 0; i < 12; i++) begin
            rdChk(mapAddr[i], mapExp[i]);
        end
        check({4'h0, measCfg.idle, measCfg.timebase}, 8'h0f);
        check(measCfg.testPol, 8'h84);
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        close_out();
    end
    initial begin
        mismatches = 0;
        check_count = 0;
        rst_n = 1'b0;
        calcStart = 1'b0;
        calcDone = 1'b0;
        rawX = 12'h000;
        rawY = 12'h000;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        check({7'h00, irqOutLowOe}, 8'h00);
        mapCheck();
        meas(100, -100, 9, 1'b1);
        yRead(scaled(-100, 9), 1'b1);
        u_jsrb_host_model.writeReg(ADDR_SCALING, 8'h16);
        u_jsrb_host_model.writeReg(ADDR_TEST_POL, 8'h84);
        u_jsrb_host_model.writeReg(ADDR_MAKER_CODE, 8'h00);
        u_jsrb_host_model.writeReg(ADDR_X_RESULT, 8'h55);
        rdChk(ADDR_MAKER_CODE, ID_MAKER_DEFAULT);
        rdChk(ADDR_X_RESULT, scaled(100, 9));
        rdChk(8'h40, 8'h00);
        rdChk(ADDR_SCALING, 8'h16);
        u_jsrb_host_model.writeReg(ADDR_MAIN_CONTROL, 8'h30);
        rdChk(ADDR_MAIN_CONTROL, 8'h31);
        check({4'h0, measCfg.idle, measCfg.timebase}, 8'h03);
        meas(100, -40, 22, 1'b1);
        yRead(scaled(-40, 22), 1'b1);
        u_jsrb_host_model.writeReg(ADDR_MAIN_CONTROL, 8'h34);
        meas(40, 0, 22, 1'b1);
        yRead(8'h00, 1'b1);
        u_jsrb_host_model.writeReg(ADDR_LIMIT_BASE, 8'h7f);
        rdChk(ADDR_LIMIT_BASE, 8'h7f);
        meas(40, 0, 22, 1'b0);
        yRead(8'h00, 1'b0);
        u_jsrb_host_model.writeReg(8'h15, 8'h01);
        meas(40, 0, 22, 1'b1);
        yRead(8'h00, 1'b1);
        u_jsrb_host_model.writeReg(ADDR_MAIN_CONTROL, 8'h38);
        meas(0, 0, 22, 1'b0);
        u_jsrb_host_model.writeReg(ADDR_MAIN_CONTROL, 8'h32);
        mapCheck();
        close_out();
    end
endmodule
bind jsrb_register_bank jsrb_properties #(.ID_MAKER(ID_MAKER)) u_jsrb_properties (
    .sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq), .regRdAck(regRdAck),
    .regRdata(regRdata), .calcDone(calcDone), .measCfg(measCfg), .irqOutLowOe(irqOutLowOe));
